// [logic/slc_params.svh]
/*
 Named constants of the sequencer core: timing, masks, lookup values,
 active-switch patterns and register offsets.
 Assumes inclusion by its bare name, definitions only.
*/
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
// Clock period and default step period
`define SLC_CLK_NS 4
`define SLC_STEP_DEF_US 2000
`define SLC_STEP_MIN 32'h2
// Switch count and patterns
`define SLC_NSW 6
`define SLC_ALL_ON 6'h3F
`define SLC_ACT_SEL0 6'h07
`define SLC_ACT_SEL1 6'h1B
`define SLC_ACT_SEL2 6'h1F
`define SLC_N_SEL0 3'h3
`define SLC_N_SEL1 3'h4
`define SLC_N_SEL2 3'h5
`define SLC_N_SEL3 3'h6
// Transition mask, 0.0256 of a step, or 0.034 of a step per fade code
`define SLC_NF_NUM 48'h100
`define SLC_NF_DEN 48'h2710
`define SLC_F_NUM 48'h22
`define SLC_F_DEN 48'h3E8
// Short thresholds in millivolts
`define SLC_VSTH0_MV 13'h578
`define SLC_VSTH1_MV 13'hE10
`define SLC_VSTH2_MV 13'hFA0
`define SLC_VSTH3_MV 13'h157C
`define SLC_VSTH4_MV 13'h1770
`define SLC_VSTH5_MV 13'h19C8
`define SLC_VSTH6_MV 13'h1C20
`define SLC_VSTH7_MV 13'h1E14
// Register offsets and responses
`define SLC_REG_STEP 8'h00
`define SLC_REG_STAT 8'h04
`define SLC_REG_FLT 8'h08
`define SLC_REG_CFG 8'h0C
`define SLC_RESP_OK 2'h0
`define SLC_RESP_ERR 2'h2
`endif

// [logic/slc_pkg.sv]
/*
 Types shared by the sequencer core and its bench.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package slc_pkg;
  // Sequence state
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_DONE} slc_state_e;
  // Latched configuration, codes 0, 1, 2 in order
  typedef struct packed {
    logic dir;
    logic [2:0] thr;
    logic [3:0] pos;
    logic [1:0] fade;
    logic [1:0] sel;
  } slc_cfg_s;
  // Per-switch detector comparators
  typedef struct packed {
    logic [5:0] open;
    logic [5:0] shrt;
    logic [5:0] trace;
  } slc_det_s;
  // Chip monitors
  typedef struct packed {
    logic pump_ready;
    logic warn;
    logic shut;
  } slc_mon_s;
endpackage
`default_nettype wire

// [logic/slc_core.sv]
/*
 Sequencer core: configuration latch, switch sequence, chain line,
 fault supervision and an AXI4-Lite register slave.
 Assumes digitised config codes, comparator outputs synchronous to clk,
 and open-drain pins resolved outside.
*/
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "slc_params.svh"
module slc_core #(
  parameter int STEP_CYCLES = `SLC_STEP_DEF_US * 1000 / `SLC_CLK_NS,
  parameter int AW = 8
) (
  // Clock, reset, freeze
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Digitised configuration codes
  input wire logic [3:0] cfg_code_threshold_dir,
  input wire logic [3:0] cfg_code_chain_position,
  input wire logic [3:0] cfg_code_switches_fade,
  // Enable and supply undervoltage
  input wire logic en,
  input wire logic uvlo,
  // Detectors and monitors
  input wire slc_pkg::slc_det_s det,
  input wire slc_pkg::slc_mon_s mon,
  input wire logic led_current_on,
  // Switch drive and threshold select
  output logic [5:0] sw_closed,
  output logic [2:0] short_threshold,
  output logic [12:0] short_threshold_mv,
  // Chain line, open drain
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  // Fault line, open drain
  input wire logic fault_out_n_in,
  output logic fault_out_n_o,
  output logic fault_out_n_oe,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import slc_pkg::*;

  // Configuration and sequence state
  slc_cfg_s cfg_r;
  logic cfg_taken_r;
  slc_state_e st_r, st_nxt;
  logic [2:0] k_r, k_nxt;
  logic [31:0] cyc_r, cyc_nxt;
  logic [31:0] step_r;
  logic [3:0] pulses_r, pulses_nxt;
  logic sync_prev_r;
  // Fault latches
  logic [5:0] open_flt_r, short_flt_r, trace_flt_r;
  logic warn_r, shut_r, fault_r;
  logic sync_oe_r;
  // Switch pattern work
  logic [5:0] act_mask, seq_closed, sw_nxt;
  logic [2:0] rk_up [`SLC_NSW];
  logic [2:0] rk_dn [`SLC_NSW];
  logic [2:0] acc_u, acc_d;
  logic [12:0] thr_mv, thr_mv_r;

  // Enabled only once codes are held and supply is good
  wire logic en_act = en && !uvlo && cfg_taken_r;
  wire logic running = (st_r == ST_RUN) || (st_r == ST_DONE);

  // Active set and step count from the switch code
  assign act_mask = (cfg_r.sel == 2'h0) ? `SLC_ACT_SEL0 :
                    (cfg_r.sel == 2'h1) ? `SLC_ACT_SEL1 :
                    (cfg_r.sel == 2'h2) ? `SLC_ACT_SEL2 :
                    `SLC_ALL_ON;
  wire logic [2:0] n_act = (cfg_r.sel == 2'h0) ? `SLC_N_SEL0 :
                           (cfg_r.sel == 2'h1) ? `SLC_N_SEL1 :
                           (cfg_r.sel == 2'h2) ? `SLC_N_SEL2 :
                           `SLC_N_SEL3;

  // Step timing
  wire logic step_end = (st_r == ST_RUN) && (cyc_r == step_r - 32'h1);
  wire logic last_step = step_end && (k_r + 3'h1 == n_act);
  wire logic sync_rise = sync_in && !sync_prev_r;

  // Masks; least times round up
  wire logic [47:0] step_w = {16'h0, step_r};
  wire logic [47:0] cyc_w = {16'h0, cyc_r};
  wire logic [47:0] mask_nf =
    (step_w * `SLC_NF_NUM + `SLC_NF_DEN - 48'h1) / `SLC_NF_DEN;
  wire logic [47:0] mask_f =
    (step_w * `SLC_F_NUM * {46'h0, cfg_r.fade} + `SLC_F_DEN - 48'h1)
    / `SLC_F_DEN;
  wire logic [47:0] trans_mask =
    (cfg_r.fade == 2'h0) ? mask_nf : mask_f;
  wire logic start_mask = (st_r == ST_RUN) && (k_r == 3'h0) &&
    (cyc_r < ((step_r + 32'h1) >> 1));
  wire logic det_mask = start_mask || (cyc_w < trans_mask);

  // Detection, only while enabled and running or done
  wire logic det_on = en_act && running;
  wire logic [5:0] open_set = det.open & {6{det_on}};
  wire logic [5:0] short_set = det.shrt & ~sw_closed &
    {6{det_on && led_current_on && !det_mask}};
  wire logic [5:0] trace_set = det.trace & sw_closed &
    {6{det_on && !det_mask}};

  // Sticky flags, wiped by enable low or undervoltage
  wire logic [5:0] open_nxt = en_act ? (open_flt_r | open_set) : 6'h00;
  wire logic [5:0] short_nxt =
    en_act ? (short_flt_r | short_set) : 6'h00;
  wire logic [5:0] trace_nxt =
    en_act ? (trace_flt_r | trace_set) : 6'h00;
  wire logic warn_nxt = en_act && (warn_r || mon.warn);
  // Shutdown survives enable low; only a supply drop clears it
  wire logic shut_nxt = !uvlo && (shut_r || mon.shut);
  wire logic pump_bad = en && !uvlo && !mon.pump_ready;
  wire logic fault_nxt = (|open_nxt) || (|short_nxt) || (|trace_nxt) ||
    warn_nxt || shut_nxt || pump_bad;

  // Step index and cycle counter
  assign k_nxt = (!en_act || st_r == ST_IDLE) ? 3'h0 :
                 step_end ? k_r + 3'h1 : k_r;
  assign cyc_nxt = (!en_act || !running || step_end) ? 32'h0 :
                   (cyc_r == 32'hFFFF_FFFF) ? cyc_r : cyc_r + 32'h1;
  assign pulses_nxt = !en_act ? 4'h0 :
    (st_r == ST_WAIT && sync_rise && pulses_r != 4'hF) ?
    pulses_r + 4'h1 : pulses_r;

  // Sequence state machine
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: if (en_act) st_nxt = ST_WAIT;
      ST_WAIT: if (pulses_r == cfg_r.pos) st_nxt = ST_RUN;
      ST_RUN: if (last_step) st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_DONE;
    endcase
    if (!en_act) st_nxt = ST_IDLE;
  end

  // Rank of each switch in both orders, target pattern
  always_comb begin
    acc_u = 3'h0;
    acc_d = 3'h0;
    seq_closed = 6'h00;
    for (int i = 0; i < `SLC_NSW; i++) begin
      rk_up[i] = acc_u;
      acc_u = acc_u + {2'h0, act_mask[i]};
      rk_dn[`SLC_NSW-1-i] = acc_d;
      acc_d = acc_d + {2'h0, act_mask[`SLC_NSW-1-i]};
    end
    for (int i = 0; i < `SLC_NSW; i++) begin
      if (!act_mask[i]) begin
        seq_closed[i] = 1'b1;
      end else if (cfg_r.dir) begin
        seq_closed[i] = (rk_up[i] >= k_nxt);
      end else begin
        seq_closed[i] = (rk_dn[i] < k_nxt);
      end
    end
  end

  // Open switches when idle; shutdown closes all
  assign sw_nxt = !en_act ? 6'h00 :
                  shut_nxt ? `SLC_ALL_ON :
                  (seq_closed | open_nxt);

  // Threshold lookup
  always_comb begin
    unique case (cfg_r.thr)
      3'h0: thr_mv = `SLC_VSTH0_MV;
      3'h1: thr_mv = `SLC_VSTH1_MV;
      3'h2: thr_mv = `SLC_VSTH2_MV;
      3'h3: thr_mv = `SLC_VSTH3_MV;
      3'h4: thr_mv = `SLC_VSTH4_MV;
      3'h5: thr_mv = `SLC_VSTH5_MV;
      3'h6: thr_mv = `SLC_VSTH6_MV;
      3'h7: thr_mv = `SLC_VSTH7_MV;
    endcase
  end

  // Codes taken once after reset; later changes ignored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= '0;
      cfg_taken_r <= 1'b0;
    end else if (ce && !cfg_taken_r) begin
      cfg_r <= {cfg_code_threshold_dir, cfg_code_chain_position,
                cfg_code_switches_fade};
      cfg_taken_r <= 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      k_r <= 3'h0;
      cyc_r <= 32'h0;
      pulses_r <= 4'h0;
      sync_prev_r <= 1'b1;
      sync_oe_r <= 1'b0;
      sw_closed <= 6'h00;
      thr_mv_r <= 13'h0;
    end else if (ce) begin
      st_r <= st_nxt;
      k_r <= k_nxt;
      cyc_r <= cyc_nxt;
      pulses_r <= pulses_nxt;
      sync_prev_r <= sync_in;
      sync_oe_r <= (st_nxt == ST_RUN);
      sw_closed <= sw_nxt;
      thr_mv_r <= thr_mv;
    end
  end

  // Fault registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      open_flt_r <= 6'h00;
      short_flt_r <= 6'h00;
      trace_flt_r <= 6'h00;
      warn_r <= 1'b0;
      shut_r <= 1'b0;
      fault_r <= 1'b0;
    end else if (ce) begin
      open_flt_r <= open_nxt;
      short_flt_r <= short_nxt;
      trace_flt_r <= trace_nxt;
      warn_r <= warn_nxt;
      shut_r <= shut_nxt;
      fault_r <= fault_nxt;
    end
  end

  // Pins: both lines only ever pull low
  assign short_threshold = cfg_r.thr;
  assign short_threshold_mv = thr_mv_r;
  assign sync_out = 1'b0;
  assign sync_oe = sync_oe_r;
  assign fault_out_n_o = 1'b0;
  assign fault_out_n_oe = fault_r;

  // AXI4-Lite slave: one write and one read in flight
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_mux, step_wr;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  wire logic aw_hs = s_axi_awvalid && s_axi_awready;
  wire logic w_hs = s_axi_wvalid && s_axi_wready;
  wire logic ar_hs = s_axi_arvalid && s_axi_arready;
  wire logic wr_go = aw_got_r && w_got_r && !bvalid_r;
  wire logic wr_step = wr_go && (awaddr_r == `SLC_REG_STEP);
  wire logic wr_map = (awaddr_r == `SLC_REG_STEP) ||
    (awaddr_r == `SLC_REG_STAT) || (awaddr_r == `SLC_REG_FLT) ||
    (awaddr_r == `SLC_REG_CFG);
  wire logic rd_map = (s_axi_araddr == `SLC_REG_STEP) ||
    (s_axi_araddr == `SLC_REG_STAT) || (s_axi_araddr == `SLC_REG_FLT) ||
    (s_axi_araddr == `SLC_REG_CFG);
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Byte-lane merge; too short a step would break the half mask
  always_comb begin
    step_wr = step_r;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) step_wr[b*8 +: 8] = wdata_r[b*8 +: 8];
    end
    if (step_wr < `SLC_STEP_MIN) step_wr = `SLC_STEP_MIN;
  end

  // Read selection
  always_comb begin
    rd_mux = 32'h0;
    if (s_axi_araddr == `SLC_REG_STEP) rd_mux = step_r;
    if (s_axi_araddr == `SLC_REG_STAT) begin
      rd_mux = {16'h0, fault_out_n_in, sync_in, st_r, 1'b0, k_r,
                2'h0, sw_closed};
    end
    if (s_axi_araddr == `SLC_REG_FLT) begin
      rd_mux = {5'h0, mon.pump_ready, shut_r, warn_r, 2'h0, trace_flt_r,
                2'h0, short_flt_r, 2'h0, open_flt_r};
    end
    if (s_axi_araddr == `SLC_REG_CFG) begin
      rd_mux = {12'h0, pulses_r, 4'h0, cfg_r};
    end
  end

  // Write channel holding registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (aw_hs) awaddr_r <= s_axi_awaddr;
      if (w_hs) wdata_r <= s_axi_wdata;
      if (w_hs) wstrb_r <= s_axi_wstrb;
      aw_got_r <= wr_go ? 1'b0 : (aw_got_r || aw_hs);
      w_got_r <= wr_go ? 1'b0 : (w_got_r || w_hs);
    end
  end

  // Responses and the step register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SLC_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r <= `SLC_RESP_OK;
      rdata_r <= 32'h0;
      step_r <= STEP_CYCLES[31:0];
    end else if (ce) begin
      if (wr_go) bresp_r <= wr_map ? `SLC_RESP_OK : `SLC_RESP_ERR;
      bvalid_r <= wr_go || (bvalid_r && !s_axi_bready);
      if (wr_step) step_r <= step_wr;
      if (ar_hs) rdata_r <= rd_mux;
      if (ar_hs) rresp_r <= rd_map ? `SLC_RESP_OK : `SLC_RESP_ERR;
      rvalid_r <= ar_hs || (rvalid_r && !s_axi_rready);
    end
  end

  // Checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wait_ready;
    ce && en_act && st_r == ST_WAIT && pulses_r == cfg_r.pos;
  endsequence
  sequence s_step_end;
    ce && en_act && step_end && !last_step;
  endsequence

  a_thr_table: assert property (
    (ce && cfg_taken_r && cfg_r.thr == 3'h7) |=>
    (short_threshold_mv == `SLC_VSTH7_MV))
    else $error("threshold lookup wrong");
  a_dimdown_start: assert property (
    (st_r == ST_WAIT && !cfg_r.dir && !shut_r) |->
    (sw_closed == ~act_mask))
    else $error("dim down start pattern wrong");
  a_dimup_start: assert property (
    (st_r == ST_WAIT && cfg_r.dir) |-> (sw_closed == `SLC_ALL_ON))
    else $error("dim up start pattern wrong");
  a_chain_start: assert property (
    s_wait_ready |=> (st_r == ST_RUN) ##0 sync_oe)
    else $error("chain start missed");
  a_unused_closed: assert property (
    (st_r != ST_IDLE) |-> ((sw_closed & ~act_mask) == ~act_mask))
    else $error("unused switch not closed");
  a_fault_drive: assert property (
    (ce && pump_bad) |=> fault_out_n_oe)
    else $error("pump fault not driven");
  a_flt_clear: assert property (
    (ce && !en_act) |=> (open_flt_r == 6'h00 && short_flt_r == 6'h00 &&
    trace_flt_r == 6'h00 && !warn_r))
    else $error("faults not cleared");
  a_shut_clear: assert property (
    (ce && uvlo) |=> !shut_r)
    else $error("shutdown not cleared by supply low");
  a_open_hold: assert property (
    (st_r != ST_IDLE) |-> ((sw_closed & open_flt_r) == open_flt_r))
    else $error("open switch not held closed");
  a_short_mask: assert property (
    (ce && det_mask) |=> ((short_flt_r & ~$past(short_flt_r)) == 6'h00))
    else $error("short set under mask");
  a_step_adv: assert property (
    s_step_end |=> (k_r == $past(k_r) + 3'h1) && (cyc_r == 32'h0))
    else $error("step did not advance");
  a_idle_open: assert property (
    (ce && !en_act) |=> (sw_closed == 6'h00) && !sync_oe)
    else $error("switches not open when idle");
endmodule
`default_nettype wire

// [bench/slc_peer.sv]
/*
 Far side of the sequencer: an upstream chained device on the chain
 line, plus the pull-ups of the chain and fault lines.
 Assumes open-drain enables that are high while pulling low.
*/
`timescale 1ns/1ps
`default_nettype none
module slc_peer (
  // Clock
  input wire logic clk,
  // Pull-down enables of the core
  input wire logic sync_oe,
  input wire logic fault_oe,
  // Resolved wire levels
  output logic sync_line,
  output logic fault_line
);
  logic peer_low_r = 1'b0; // Upstream device running its sequence
  // Pull-up wins once every party has let go
  assign sync_line = !(sync_oe || peer_low_r);
  assign fault_line = !fault_oe;
  // Hold the line low for a whole upstream run, then release it
  task automatic pulse(input int low_cycles);
    @(posedge clk);
    peer_low_r <= 1'b1;
    repeat (low_cycles) @(posedge clk);
    peer_low_r <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
/*
 Bench of slc_core: bus cases, then a table of configurations run end
 to end, then chain, mask and fault cases. Assumes slc_peer for the pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import slc_pkg::*;
  localparam int STEP = 200; // Short step keeps runs brief
  // Row: codes in, threshold and active set out
  typedef struct packed {
    logic [3:0] c0;
    logic [3:0] c2;
    logic [12:0] mv;
    logic [5:0] act;
  } slc_row_s;
  slc_row_s rows [8] = '{
    '{4'h0, 4'h0, 13'h578, 6'h07}, '{4'h9, 4'h1, 13'hE10, 6'h1B},
    '{4'h2, 4'h2, 13'hFA0, 6'h1F}, '{4'hB, 4'h3, 13'h157C, 6'h3F},
    '{4'h4, 4'h4, 13'h1770, 6'h07}, '{4'hD, 4'h9, 13'h19C8, 6'h1B},
    '{4'h6, 4'hE, 13'h1C20, 6'h1F}, '{4'hF, 4'hF, 13'h1E14, 6'h3F}};
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, uvlo = 1'b0, led = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once to test freezing
  logic [3:0] c0 = 4'h0, c1 = 4'h0, c2 = 4'h0;
  slc_det_s det = '0;
  slc_mon_s mon = 3'h4; // Pump ready, no thermal flags
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [5:0] sw;
  logic [12:0] mv;
  logic [2:0] thr;
  logic sync_oe, sync_line, flt_oe, flt_line;
  int num_errors = 0, n_checks = 0, pos = 0;
  slc_core #(.STEP_CYCLES(STEP)) slc_core_inst (
    .clk(clk), .rstn(rstn), .ce(ce),
    .cfg_code_threshold_dir(c0), .cfg_code_chain_position(c1),
    .cfg_code_switches_fade(c2), .en(en), .uvlo(uvlo), .det(det),
    .mon(mon), .led_current_on(led), .sw_closed(sw),
    .short_threshold(thr), .short_threshold_mv(mv),
    .sync_in(sync_line), .sync_out(), .sync_oe(sync_oe),
    .fault_out_n_in(flt_line), .fault_out_n_o(), .fault_out_n_oe(flt_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  slc_peer slc_peer_inst (.clk(clk), .sync_oe(sync_oe),
    .fault_oe(flt_oe), .sync_line(sync_line), .fault_line(flt_line));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compare with case equality and count
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // A limit ran out: count it and stop
  task automatic hang(input string s);
    chk(s, 1, 0);
    print_verdict();
  endtask
  // Reset with new codes; enable stays low
  task automatic start(input logic [3:0] a, b, c);
    @(posedge clk);
    rstn <= 1'b0;
    en <= 1'b0;
    uvlo <= 1'b0;
    mon <= 3'h4;
    {c0, c1, c2} <= {a, b, c};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // One bus transfer, write when w; answer left in q and r
  task automatic axi(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic ta, tw, tr;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (int i = 0; i < 40; i++) begin
      // Sample mid-cycle, act right after the edge
      @(negedge clk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tr = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
      if (tr) begin
        bready <= 1'b0;
        rready <= 1'b0;
        return;
      end
    end
    hang("bus answer");
  endtask
  // Wait for chain drive level v; edge count restarts there
  task automatic wait_oe(input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (sync_oe === v) begin
        pos = 0;
        return;
      end
    end
    hang("chain drive wait");
  endtask
  // Advance to edge e after the chain drive rose
  task automatic goto(input int e);
    repeat (e - pos) @(posedge clk);
    pos = e;
  endtask
  // Detector pulse seen in cycle e of the run, fault line judged after
  task automatic hit(input int e, input slc_det_s d, input logic l,
                     input logic f);
    goto(e);
    det <= d;
    led <= l;
    goto(e + 1);
    det <= '0;
    led <= 1'b0;
    goto(e + 3);
    #1;
    chk("fault drive", f, flt_oe);
  endtask
  // Follow one sequence from chain drive rise to its release
  task automatic run_seq(input logic up, input logic [5:0] act);
    logic [5:0] prev, d;
    logic ok;
    int t, k;
    prev = sw;
    t = 0;
    k = 0;
    chk("start", up ? 6'h3F : 6'h3F ^ act, sw);
    while (sync_oe === 1'b1) begin
      @(negedge clk);
      t++;
      if (t > 8 * STEP) hang("sequence end");
      d = sw ^ prev;
      prev = sw;
      if (d != 6'h0) begin
        k++;
        // Next switch must be the lowest closed or highest open one
        ok = up ? (act & sw & ((d << 1) - 6'h1)) == 6'h0
                : (act & ~sw) < d;
        chk("step time", k * STEP, t);
        chk("one switch", 1, $onehot(d));
        chk("order", 1, ok && (d & act) != 6'h0);
      end
    end
    chk("steps", $countones(act), k);
    chk("end", up ? 6'h3F ^ act : 6'h3F, sw);
    chk("chain release", 1, sync_line);
  endtask
  // Hang guard for the whole run
  initial begin
    repeat (100000) @(posedge clk);
    hang("run time");
  end
  initial begin
    // Bus: clamp, read-only and unmapped places
    start(4'h0, 4'h0, 4'h3);
    axi(1'b1, 8'h00, 32'h1);
    axi(1'b0, 8'h00, 32'h0);
    chk("step clamp", 32'h2, q);
    axi(1'b1, 8'h00, STEP);
    axi(1'b0, 8'h00, 32'h0);
    chk("step", STEP, q);
    axi(1'b1, 8'h04, 32'h0);
    chk("read-only resp", 2'h0, r);
    axi(1'b1, 8'h40, 32'h0);
    chk("unmapped write", 2'h2, r);
    axi(1'b0, 8'h40, 32'h0);
    chk("unmapped read resp", 2'h2, r);
    chk("unmapped read data", 0, q);
    // Configuration table
    foreach (rows[i]) begin
      start(rows[i].c0, 4'h0, rows[i].c2);
      @(negedge clk);
      chk("idle switches", 0, sw);
      axi(1'b0, 8'h0C, 32'h0);
      chk("codes", {rows[i].c0, 4'h0, rows[i].c2}, q[11:0]);
      en <= 1'b1;
      wait_oe(1'b1, 8);
      chk("threshold", rows[i].mv, mv);
      chk("threshold code", rows[i].c0[2:0], thr);
      run_seq(rows[i].c0[3], rows[i].act);
    end
    // Position two, code changed after latching
    start(4'h0, 4'h2, 4'h3);
    c1 <= 4'h0;
    en <= 1'b1;
    slc_peer_inst.pulse(10);
    repeat (20) @(negedge clk);
    chk("early start", 0, sync_oe);
    slc_peer_inst.pulse(10);
    wait_oe(1'b1, 4);
    // Short masks and qualifiers, no fade
    start(4'h0, 4'h0, 4'h3);
    en <= 1'b1;
    wait_oe(1'b1, 8);
    hit(50, 18'h40, 1'b1, 1'b0);
    hit(203, 18'h40, 1'b1, 1'b0);
    hit(208, 18'h40, 1'b0, 1'b0);
    hit(212, 18'h800, 1'b1, 1'b0);
    hit(217, 18'h40, 1'b1, 1'b1);
    wait_oe(1'b0, 8 * STEP);
    chk("short keeps sequence", 6'h3F, sw);
    // Longest fade mask
    start(4'h0, 4'h0, 4'hF);
    en <= 1'b1;
    wait_oe(1'b1, 8);
    hit(215, 18'h40, 1'b1, 1'b0);
    hit(225, 18'h40, 1'b1, 1'b1);
    // Open LED while dimming up, then clears
    start(4'h8, 4'h0, 4'h3);
    en <= 1'b1;
    wait_oe(1'b1, 8);
    hit(120, 18'h2000, 1'b0, 1'b1);
    wait_oe(1'b0, 8 * STEP);
    chk("open held closed", 6'h02, sw);
    @(posedge clk);
    en <= 1'b0;
    repeat (3) @(negedge clk);
    chk("enable low clears", 0, flt_oe);
    chk("enable low opens", 0, sw);
    @(posedge clk);
    en <= 1'b1;
    wait_oe(1'b1, 8);
    hit(120, 18'h01, 1'b0, 1'b1);
    @(posedge clk);
    uvlo <= 1'b1;
    repeat (3) @(negedge clk);
    chk("supply low clears", 0, flt_oe);
    // Thermal and pump flags
    @(posedge clk);
    uvlo <= 1'b0;
    mon <= 3'h6;
    repeat (4) @(negedge clk);
    chk("warning", 1, flt_oe);
    @(posedge clk);
    en <= 1'b0;
    mon <= 3'h0;
    repeat (3) @(negedge clk);
    chk("warning cleared", 0, flt_oe);
    @(posedge clk);
    en <= 1'b1;
    repeat (4) @(negedge clk);
    chk("pump not ready", 1, flt_oe);
    @(posedge clk);
    mon <= 3'h5;
    repeat (4) @(negedge clk);
    chk("shutdown closes", 6'h3F, sw);
    // Frozen enable holds all state, even with supply low
    @(posedge clk);
    ce <= 1'b0;
    uvlo <= 1'b1;
    repeat (3) @(negedge clk);
    chk("freeze switches", 6'h3F, sw);
    chk("freeze fault", 1, flt_oe);
    // Thawed: supply low opens switches and clears shutdown
    @(posedge clk);
    ce <= 1'b1;
    repeat (3) @(negedge clk);
    chk("supply low opens", 0, sw);
    chk("supply low clears shutdown", 0, flt_oe);
    print_verdict();
  end
endmodule
`default_nettype wire
